// ===== logic/sdc_buf2.sv
`timescale 1ns/1ps
module sdc_buf2
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Fill side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  // Drain side
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       rd_q;
  logic       rd_d;
  logic       wr_q;
  logic       wr_d;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    mem_d = mem_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
    end
    wr_d  = push ? ~wr_q : wr_q;
    rd_d  = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      cnt_q    <= 2'h0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
    end
    else
    begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q  <= rd_d;
      wr_q  <= wr_d;
    end
  end
endmodule

// ===== logic/sdc_read_cmds.sv
// Operation
// - Commands and responses share one two-way debug pin.
// - Command 0x07 returns a 64-bit trace line as two longwords.
// - First longword is line bits 31..0, second is bits 63..32.
// - With ACK enabled, pulse ACK before each ready trace longword.
// - Second trace longword fetch may still time out after first ACK.
// - Without a trace buffer the trace read returns 0x00 bytes.
// - Command 0x54 re-reads previous read address, returns 16 bits after ACK.
// - Command 0x55 returns status byte after delay, before data bytes.
// - Status byte reflects state after the memory access completed.
// - Status variant drives ACK before the data bytes when enabled.
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_read_cmds
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Debug pin
  input  wire logic        debug_wire_pin_in,
  output logic             debug_wire_pin_out,
  output logic             debug_wire_pin_oe,
  // Decoded command from the shared serial engine
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  output logic             cmd_busy,
  // Controller configuration
  input  wire logic        ack_enable,
  input  wire logic        trace_present,
  input  wire logic [7:0]  debug_ctrl_status_low,
  // Internal access port
  output logic             acc_req,
  output logic             acc_trace,
  output logic             acc_half,
  output logic [31:0]      acc_addr,
  input  wire logic [31:0] prev_read_addr,
  input  wire logic        acc_done,
  input  wire logic [31:0] acc_data,
  // Status
  output logic             timeout_flag
);
  sdc_pkg::sdc_state_t st_q;
  sdc_pkg::sdc_state_t st_d;
  logic [31:0] word_q;
  logic [31:0] word_d;
  logic [2:0]  left_q;
  logic [2:0]  left_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic        second_q;
  logic        second_d;
  logic        to_q;
  logic        to_d;
  logic        ack_drive;
  logic        bv;
  logic        br;
  logic [7:0]  bd;
  logic        tx_v;
  logic        tx_r;
  logic [7:0]  tx_d;
  logic        tx_out;
  logic        tx_oe;

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [2:0] n);
    // Leftmost remaining byte is the most significant one.
    logic [7:0] b;
    b = 8'h00;
    case (n)
      3'h4: b = w[31:24];
      3'h3: b = w[23:16];
      3'h2: b = w[15:8];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  assign cmd_busy     = (st_q != sdc_pkg::SDC_IDLE);
  assign timeout_flag = to_q;
  assign acc_addr     = prev_read_addr;
  assign acc_half     = (cmd_q != `SDC_CMD_TRACE);
  assign acc_trace    = (cmd_q == `SDC_CMD_TRACE);
  assign acc_req      = (st_q == sdc_pkg::SDC_FETCH) || (st_q == sdc_pkg::SDC_FETCH2);
  // The ACK pulse waits for a quiet bit engine so it never overwrites a byte still being shifted.
  assign ack_drive    = (st_q == sdc_pkg::SDC_ACK) && !tx_oe && !tx_v;
  assign bv           = (st_q == sdc_pkg::SDC_SEND) || (st_q == sdc_pkg::SDC_STATUS);
  assign bd           = (st_q == sdc_pkg::SDC_STATUS) ? debug_ctrl_status_low : pick_byte(word_q, left_q);

  // Response bytes pass a two-entry buffer so the bit engine may stall.
  sdc_buf2 u_buf
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (bv),
    .in_ready  (br),
    .in_data   (bd),
    .out_valid (tx_v),
    .out_ready (tx_r),
    .out_data  (tx_d)
  );

  sdc_tx u_tx
  (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .byte_valid (tx_v),
    .byte_ready (tx_r),
    .byte_data  (tx_d),
    .pin_out    (tx_out),
    .pin_oe     (tx_oe)
  );

  // single pin
  // The ACK pulse drives low; the pin input is unused here because
  // command bytes arrive already decoded from the shared engine.
  assign debug_wire_pin_out = ack_drive ? 1'b0 : tx_out;
  assign debug_wire_pin_oe  = ack_drive || tx_oe;

  always_comb
  begin
    st_d     = st_q;
    word_d   = word_q;
    left_d   = left_q;
    cnt_d    = cnt_q;
    cmd_d    = cmd_q;
    second_d = second_q;
    to_d     = to_q;
    case (st_q)
      sdc_pkg::SDC_IDLE:
      begin
        if (cmd_valid && ((cmd_code == `SDC_CMD_TRACE) || (cmd_code == `SDC_CMD_SAME)
            || (cmd_code == `SDC_CMD_SAME_WS)))
        begin
          cmd_d    = cmd_code;
          second_d = 1'b0;
          cnt_d    = 8'h00;
          to_d     = 1'b0;
          st_d     = sdc_pkg::SDC_CMD;
        end
      end
      sdc_pkg::SDC_CMD:
      begin
        st_d = sdc_pkg::SDC_FETCH;
      end
      sdc_pkg::SDC_FETCH, sdc_pkg::SDC_FETCH2:
      begin
        if ((cmd_q == `SDC_CMD_TRACE) && !trace_present)
        begin
          word_d = {4{`SDC_NO_TRACE_DATA}};
          cnt_d  = 8'h00;
          st_d   = ack_enable ? sdc_pkg::SDC_ACK : sdc_pkg::SDC_SEND;
        end
        else if (acc_done)
        begin
          word_d = acc_data;
          cnt_d  = 8'h00;
          if (cmd_q == `SDC_CMD_SAME_WS)
          begin
            st_d = sdc_pkg::SDC_STATUS;
          end
          else
          begin
            st_d = ack_enable ? sdc_pkg::SDC_ACK : sdc_pkg::SDC_SEND;
          end
        end
        else if (cnt_q == 8'(`SDC_TIMEOUT_CYC - 1))
        begin
          to_d = 1'b1;
          st_d = sdc_pkg::SDC_IDLE;
        end
        else
        begin
          cnt_d = cnt_q + 8'h01;
        end
        left_d = (cmd_q == `SDC_CMD_TRACE) ? 3'(`SDC_LW_BYTES) : 3'(`SDC_WORD_BYTES);
      end
      sdc_pkg::SDC_STATUS:
      begin
        if (br)
        begin
          cnt_d = 8'h00;
          st_d  = ack_enable ? sdc_pkg::SDC_ACK : sdc_pkg::SDC_SEND;
        end
      end
      sdc_pkg::SDC_ACK:
      begin
        if (!tx_oe && !tx_v)
        begin
          if (cnt_q == 8'(`SDC_ACK_CYC - 1))
          begin
            cnt_d = 8'h00;
            st_d  = sdc_pkg::SDC_SEND;
          end
          else
          begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      sdc_pkg::SDC_SEND:
      begin
        if (br)
        begin
          left_d = left_q - 3'h1;
          if (left_q == 3'h1)
          begin
            cnt_d = 8'h00;
            st_d  = ((cmd_q == `SDC_CMD_TRACE) && !second_q) ? sdc_pkg::SDC_GAP : sdc_pkg::SDC_DONE;
          end
        end
      end
      sdc_pkg::SDC_GAP:
      begin
        second_d = 1'b1;
        if (!tx_oe && !tx_v)
        begin
          if (ack_enable || (cnt_q == 8'(`SDC_GAP_CYC * `SDC_CLKS_PER_BIT - 1)))
          begin
            cnt_d = 8'h00;
            st_d  = sdc_pkg::SDC_FETCH2;
          end
          else
          begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      sdc_pkg::SDC_DONE:
      begin
        if (!tx_oe && !tx_v)
        begin
          st_d = sdc_pkg::SDC_IDLE;
        end
      end
      default:
      begin
        st_d = sdc_pkg::SDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q     <= sdc_pkg::SDC_IDLE;
      word_q   <= 32'h0000_0000;
      left_q   <= 3'h0;
      cnt_q    <= 8'h00;
      cmd_q    <= 8'h00;
      second_q <= 1'b0;
      to_q     <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      word_q   <= word_d;
      left_q   <= left_d;
      cnt_q    <= cnt_d;
      cmd_q    <= cmd_d;
      second_q <= second_d;
      to_q     <= to_d;
    end
  end

  pin_ack_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    ack_drive |-> (debug_wire_pin_oe && !debug_wire_pin_out))
    else $error("ack pulse not low on pin");

  ack_then_send_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_ACK) && (st_d == sdc_pkg::SDC_SEND) |-> cnt_q == 8'(`SDC_ACK_CYC - 1))
    else $error("ack pulse length wrong");

  status_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_STATUS) && br && ack_enable |=> st_q == sdc_pkg::SDC_ACK)
    else $error("no ack after status byte");

  status_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_FETCH) && acc_done && (cmd_q == `SDC_CMD_SAME_WS) |=> st_q == sdc_pkg::SDC_STATUS)
    else $error("status byte not next");

  status_value_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_STATUS) |-> $past(acc_done) || ($past(st_q) == sdc_pkg::SDC_STATUS))
    else $error("status byte taken before access end");

  no_trace_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_FETCH) && (cmd_q == `SDC_CMD_TRACE) && !trace_present |=> word_q == {4{`SDC_NO_TRACE_DATA}})
    else $error("trace data not zero");

  fetch_timeout_a: assert property (@(posedge clk_sys) disable iff (rst)
    acc_req && !acc_done && cnt_q == 8'(`SDC_TIMEOUT_CYC - 1) && !(cmd_q == `SDC_CMD_TRACE && !trace_present)
    |=> to_q && !cmd_busy)
    else $error("timeout not raised");

  msb_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_SEND) && (left_q == 3'h4) |-> bd == word_q[31:24])
    else $error("byte order wrong");

  second_fetch_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == sdc_pkg::SDC_GAP) && (st_d == sdc_pkg::SDC_FETCH2) |-> cmd_q == `SDC_CMD_TRACE)
    else $error("second fetch outside trace read");
endmodule

// ===== logic/sdc_tx.sv
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_tx
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Byte in
  input  wire logic       byte_valid,
  output logic            byte_ready,
  input  wire logic [7:0] byte_data,
  // Pin drive
  output logic            pin_out,
  output logic            pin_oe
);
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [3:0] tick_q;
  logic [3:0] tick_d;
  logic       busy_q;
  logic       busy_d;

  assign byte_ready = !busy_q;

  // Bits leave MSB first, each held a fixed number of clocks.
  always_comb
  begin
    sh_d   = sh_q;
    bit_d  = bit_q;
    tick_d = tick_q;
    busy_d = busy_q;
    if (!busy_q && byte_valid)
    begin
      sh_d   = byte_data;
      bit_d  = 4'h0;
      tick_d = 4'h0;
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (tick_q == 4'(`SDC_CLKS_PER_BIT - 1))
      begin
        tick_d = 4'h0;
        sh_d   = {sh_q[6:0], 1'b0};
        bit_d  = bit_q + 4'h1;
        busy_d = (bit_q != 4'h7);
      end
      else
      begin
        tick_d = tick_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sh_q   <= 8'h00;
      bit_q  <= 4'h0;
      tick_q <= 4'h0;
      busy_q <= 1'b0;
      pin_out <= 1'b1;
      pin_oe  <= 1'b0;
    end
    else
    begin
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      tick_q <= tick_d;
      busy_q <= busy_d;
      pin_out <= busy_d ? sh_d[7] : 1'b1;
      pin_oe  <= busy_d;
    end
  end
endmodule

// ===== pkg/sdc_defs.svh
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
`define SDC_CMD_TRACE      8'h07
`define SDC_CMD_SAME       8'h54
`define SDC_CMD_SAME_WS    8'h55
`define SDC_NO_TRACE_DATA  8'h00
`define SDC_GAP_CYC        16
`define SDC_CLKS_PER_BIT   8
`define SDC_ACK_CYC        8
`define SDC_TIMEOUT_CYC    256
`define SDC_LW_BYTES       4
`define SDC_WORD_BYTES     2
`endif

// ===== pkg/sdc_pkg.sv
package sdc_pkg;
  typedef enum logic [3:0] {
    SDC_IDLE     = 4'b0000,
    SDC_CMD      = 4'b0001,
    SDC_FETCH    = 4'b0011,
    SDC_ACK      = 4'b0010,
    SDC_SEND     = 4'b0110,
    SDC_GAP      = 4'b0111,
    SDC_FETCH2   = 4'b0101,
    SDC_STATUS   = 4'b0100,
    SDC_DONE     = 4'b1100
  } sdc_state_t;
endpackage

// ===== tb/sdc_host_model.sv
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_host_model
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Debug wire
  input  wire logic debug_wire_pin_out,
  input  wire logic debug_wire_pin_oe,
  output logic      debug_wire_pin_in,
  // Capture control
  input  wire logic rx_clear
);
  logic rx_bits [0:255];
  int   rx_time [0:255];
  int   rx_cnt;
  int   phase;
  int   cyc = 0;

  // one shared wire
  // The host only listens here, so the pull-up holds the wire high while the target lets go.
  assign debug_wire_pin_in = debug_wire_pin_oe ? debug_wire_pin_out : 1'b1;

  always @(posedge clk_sys)
    cyc <= cyc + 1;

  // host pacing
  // Bits are taken mid-cell and time-stamped, so the pause between longwords can be judged.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst || rx_clear)
    begin
      rx_cnt <= 0;
      phase <= 0;
    end
    else
    begin
      phase <= debug_wire_pin_oe ? (phase + 1) % `SDC_CLKS_PER_BIT : 0;
      if (debug_wire_pin_oe && phase == `SDC_CLKS_PER_BIT / 2 - 1 && rx_cnt < 256)
      begin
        rx_bits[rx_cnt] <= debug_wire_pin_out;
        rx_time[rx_cnt] <= cyc;
        rx_cnt <= rx_cnt + 1;
      end
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "sdc_defs.svh"
module tb;
  logic        clk_sys;
  logic        rst;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        ack_enable;
  logic        trace_present;
  logic [7:0]  debug_ctrl_status_low;
  logic [7:0]  stat_after;
  logic [31:0] prev_read_addr;
  logic        acc_done;
  logic [31:0] acc_data;
  logic        rx_clear;
  wire         pin_in;
  wire         pin_out;
  wire         pin_oe;
  wire         cmd_busy;
  wire         acc_req;
  wire         acc_trace;
  wire         acc_half;
  wire  [31:0] acc_addr;
  wire         timeout_flag;
  logic [31:0] data_w [0:1];
  int          fetch_lat [0:1];
  int          nfetch;
  int          cnt;
  logic        last_trace;
  logic        last_half;
  logic [31:0] last_addr;
  logic        exp_q [$];
  int          fail_count = 0;
  int          tests_run = 0;

  sdc_read_cmds uut (.clk_sys(clk_sys), .rst(rst), .debug_wire_pin_in(pin_in), .debug_wire_pin_out(pin_out),
    .debug_wire_pin_oe(pin_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_busy(cmd_busy),
    .ack_enable(ack_enable), .trace_present(trace_present), .debug_ctrl_status_low(debug_ctrl_status_low),
    .acc_req(acc_req), .acc_trace(acc_trace), .acc_half(acc_half), .acc_addr(acc_addr),
    .prev_read_addr(prev_read_addr), .acc_done(acc_done), .acc_data(acc_data), .timeout_flag(timeout_flag));

  sdc_host_model host (.clk_sys(clk_sys), .rst(rst), .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe),
    .debug_wire_pin_in(pin_in), .rx_clear(rx_clear));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Fetch responder; the status byte changes with the completed access so a stale sample shows up.
  always @(posedge clk_sys)
  begin
    acc_done <= 1'b0;
    if (!acc_req || acc_done)
      cnt <= 0;
    else
    begin
      cnt <= cnt + 1;
      if (cnt == fetch_lat[nfetch % 2])
      begin
        acc_done <= 1'b1;
        acc_data <= data_w[nfetch % 2];
        last_trace <= acc_trace;
        last_half <= acc_half;
        last_addr <= acc_addr;
        debug_ctrl_status_low <= stat_after;
        nfetch <= nfetch + 1;
      end
    end
  end

  task automatic print_verdict();
    $display("Checks: %0d, mismatches: %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic push_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      exp_q.push_back(b[i]);
  endtask

  task automatic wait_busy(input logic lvl, input int limit);
    int n;
    n = 0;
    #1;
    while (cmd_busy !== lvl)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > limit)
      begin
        chk1(cmd_busy, lvl, "busy wait");
        print_verdict();
      end
    end
  endtask

  task automatic run_cmd(input logic [7:0] code, input logic ack);
    @(posedge clk_sys);
    ack_enable <= ack;
    debug_ctrl_status_low <= 8'h3C;
    nfetch = 0;
    rx_clear <= 1'b1;
    @(posedge clk_sys);
    rx_clear <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    wait_busy(1'b1, 8);
    wait_busy(1'b0, 6000);
    repeat (16) @(posedge clk_sys);
  endtask

  task automatic check_stream();
    chk32(32'(host.rx_cnt), 32'(exp_q.size()), "bit count");
    for (int i = 0; i < exp_q.size() && i < host.rx_cnt; i++)
      chk1(host.rx_bits[i], exp_q[i], "wire bit");
    exp_q = {};
  endtask

  task automatic sc_trace(input logic ack, input logic present, input int lat2);
    logic [63:0] line;
    line = 64'h0123_4567_89AB_CDEF;
    trace_present <= present;
    data_w[0] = line[31:0];
    data_w[1] = line[63:32];
    fetch_lat[1] = lat2;
    for (int lw = 0; lw < (lat2 > `SDC_TIMEOUT_CYC ? 1 : 2); lw++)
    begin
      if (ack)
        exp_q.push_back(1'b0);
      for (int b = 3; b >= 0; b--)
        push_byte(present ? line[lw * 32 + b * 8 +: 8] : `SDC_NO_TRACE_DATA);
    end
    run_cmd(`SDC_CMD_TRACE, ack);
    check_stream();
    chk1(timeout_flag, lat2 > `SDC_TIMEOUT_CYC, "timeout flag");
    if (present)
      chk1(last_trace, 1'b1, "trace fetch");
    if (present)
      chk1(last_half, 1'b0, "trace fetch width");
    if (!ack && present)
      chk1(host.rx_time[32] - host.rx_time[31] >= (`SDC_GAP_CYC + 1) * `SDC_CLKS_PER_BIT, 1'b1, "gap");
    fetch_lat[1] = 5;
  endtask

  task automatic sc_same(input logic [7:0] code, input logic ack);
    prev_read_addr <= 32'h0000_1234;
    data_w[0] = 32'h0000_A55A;
    data_w[1] = 32'h0000_A55A;
    if (code == `SDC_CMD_SAME_WS)
      push_byte(stat_after);
    if (ack)
      exp_q.push_back(1'b0);
    push_byte(8'hA5);
    push_byte(8'h5A);
    run_cmd(code, ack);
    check_stream();
    chk32(last_addr, 32'h0000_1234, "fetch address");
    chk1(last_half, 1'b1, "word fetch width");
    chk1(timeout_flag, 1'b0, "flag cleared");
  endtask

  task automatic sc_unknown();
    run_cmd_nowait(8'h12);
  endtask

  task automatic run_cmd_nowait(input logic [7:0] code);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk1(cmd_busy, 1'b0, "unknown busy");
    chk1(acc_req, 1'b0, "unknown fetch");
  endtask

  // A reset in the middle of a trace read must drop the pin and abandon the command.
  task automatic sc_reset();
    @(posedge clk_sys);
    ack_enable <= 1'b1;
    cmd_valid <= 1'b1;
    cmd_code <= `SDC_CMD_TRACE;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk1(pin_oe, 1'b0, "reset drive");
    chk1(cmd_busy, 1'b0, "reset busy");
    chk1(acc_req, 1'b0, "reset fetch");
    chk1(timeout_flag, 1'b0, "reset flag");
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    ack_enable = 1'b1;
    trace_present = 1'b1;
    debug_ctrl_status_low = 8'h3C;
    stat_after = 8'hC3;
    prev_read_addr = 32'h0000_0000;
    acc_done = 1'b0;
    acc_data = 32'h0000_0000;
    rx_clear = 1'b0;
    fetch_lat[0] = 5;
    fetch_lat[1] = 5;
    nfetch = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    sc_trace(1'b1, 1'b1, 5);
    sc_trace(1'b0, 1'b1, 5);
    sc_trace(1'b1, 1'b0, 5);
    sc_trace(1'b1, 1'b1, 300);
    sc_reset();
    for (int a = 0; a < 2; a++)
    begin
      sc_same(`SDC_CMD_SAME, a[0]);
      sc_same(`SDC_CMD_SAME_WS, a[0]);
    end
    sc_unknown();
    print_verdict();
  end
endmodule
